// *** logic/tzc_pkg.sv ***
package tzc_pkg;
  // ==========================================
  // clock and timing
  localparam longint unsigned CLK_HZ = 64'd25_000_000;
  localparam longint unsigned STATUS_PERIOD_S = 64'd3600;
  localparam longint unsigned STATUS_PERIOD_CYCLES = STATUS_PERIOD_S * CLK_HZ;

  // ==========================================
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_ZONE = 8'h08;
  localparam logic [7:0] REG_MEM = 8'h0c;

  // ==========================================
  // control field positions and reset
  localparam int CTRL_CODE_LSB = 0;
  localparam int CTRL_SYS_LSB = 8;
  localparam int CTRL_STATUS_KEY = 16;
  localparam int CTRL_RESTORE_KEY = 17;
  localparam int CTRL_AUTO_LSB = 18;
  localparam int CTRL_ALERT_LSB = 22;
  localparam int CTRL_ARMED = 25;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // ==========================================
  // status register field positions
  localparam int STAT_ILLEGAL_BIT = 3;
  localparam int STAT_FOREIGN_BIT = 4;
  localparam int STAT_SEEN_LSB = 8;

  // ==========================================
  // code switch layout and zone attributes
  localparam int ZONE_BITS = 3;
  localparam int CHAN_BITS = 5;
  localparam logic [7:0] ILLEGAL_CODE = 8'hff;
  localparam logic [7:0] EXIT_ENTRY_MASK = 8'h07;
  localparam logic [7:0] ALWAYS_RESTORE_MASK = 8'hc0;
  localparam logic [7:0] SEMI_SUPERVISED_MASK = 8'hc0;
  localparam int AUTO_OPT_FIRST = 2;
  localparam int ALERT_OPT_FIRST = 5;

  // ==========================================
  // report carrier
  typedef enum logic [1:0] {
    KIND_ALARM = 2'b00,
    KIND_RESTORE = 2'b01,
    KIND_STATUS = 2'b11,
    KIND_TEST = 2'b10
  } tzc_kind_t;

  typedef struct packed {
    tzc_kind_t kind;
    logic [7:0] system;
    logic [7:0] code;
    logic lowBattery;
    logic contactFault;
  } tzc_report_t;
endpackage

// *** logic/tzc_zone_channel.sv ***
// Chosen here: the address map and register access over APB.
module tzc_zone_channel import tzc_pkg::*; #(
  parameter longint unsigned STATUS_CYCLES = STATUS_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmitter side
  input wire logic contactPin,
  input wire logic lowBatteryIn,
  output tzc_report_t txReport,
  output logic txValid,
  // receiver side
  input wire tzc_report_t rxReport,
  input wire logic rxValid,
  output logic [7:0] zoneOut,
  output logic [2:0] rxZone,
  output logic [4:0] rxChannel
);
  // ==========================================
  // code decode helpers
  function automatic logic [2:0] zoneIndex(input logic [7:0] code);
    zoneIndex = code[7 -: ZONE_BITS];
  endfunction

  function automatic logic [4:0] chanIndex(input logic [7:0] code);
    chanIndex = code[CHAN_BITS-1:0];
  endfunction

  // ==========================================
  // registers
  logic [31:0] ctrl;
  logic [7:0] alarmMemory;
  logic [7:0] statusSeen;
  logic illegalSeen;
  logic foreignSeen;

  wire logic access = psel && penable && !pready;
  // writes land at the edge where the master sees pready high
  wire logic wrStrobe = psel && penable && pready && pwrite;
  wire logic mapped = (paddr == REG_CTRL) || (paddr == REG_STAT) || (paddr == REG_ZONE) || (paddr == REG_MEM);

  wire logic [7:0] mySystem = ctrl[CTRL_SYS_LSB +: 8];
  wire logic [7:0] myCode = ctrl[CTRL_CODE_LSB +: 8];
  wire logic statusKey = ctrl[CTRL_STATUS_KEY];
  wire logic restoreKey = ctrl[CTRL_RESTORE_KEY];
  wire logic armed = ctrl[CTRL_ARMED];

  // ==========================================
  // zone attribute masks
  logic [7:0] selfRestore;
  logic [7:0] unarmedAlert;
  always_comb begin
    selfRestore = ALWAYS_RESTORE_MASK;
    selfRestore[AUTO_OPT_FIRST +: 4] = ctrl[CTRL_AUTO_LSB +: 4];
    unarmedAlert = 8'h00;
    unarmedAlert[ALERT_OPT_FIRST +: 3] = ctrl[CTRL_ALERT_LSB +: 3];
  end

  // ==========================================
  // apb
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      pslverr <= access && !mapped;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (access && !pwrite) begin
      case (paddr)
        REG_CTRL: prdata <= ctrl;
        REG_STAT: prdata <= {16'h0000, statusSeen, 3'h0, foreignSeen, illegalSeen, rxZone};
        REG_ZONE: prdata <= {selfRestore, unarmedAlert, EXIT_ENTRY_MASK, zoneOut};
        REG_MEM: prdata <= {16'h0000, ~SEMI_SUPERVISED_MASK, alarmMemory};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
    end else if (wrStrobe && paddr == REG_CTRL) begin
      ctrl <= pwdata;
    end
  end

  // ==========================================
  // contact input synchroniser
  logic [2:0] contactSync;
  logic contactState;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      contactSync <= 3'h0;
      contactState <= 1'b0;
    end else begin
      contactSync <= {contactSync[1:0], contactPin};
      if (contactSync[1] == contactSync[2]) begin
        contactState <= contactSync[2];
      end
    end
  end

  wire logic next_contact = (contactSync[1] == contactSync[2]) ? contactSync[2] : contactState;
  wire logic restoreEvent = contactState && !next_contact;

  // ==========================================
  // transmitter reports
  logic [63:0] statusTimer;
  logic statusPending;
  wire logic statusTick = !statusKey && (statusTimer == STATUS_CYCLES - 64'd1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      statusTimer <= 64'd0;
    end else if (statusKey || statusTick) begin
      statusTimer <= 64'd0;
    end else begin
      statusTimer <= statusTimer + 64'd1;
    end
  end

  wire logic sendRestore = restoreEvent && !restoreKey;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      statusPending <= 1'b0;
    end else if (statusTick && sendRestore) begin
      statusPending <= 1'b1;
    end else if (!sendRestore) begin
      statusPending <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txValid <= 1'b0;
      txReport <= '0;
    end else begin
      txValid <= sendRestore || statusTick || statusPending;
      txReport.system <= mySystem;
      txReport.code <= myCode;
      txReport.lowBattery <= lowBatteryIn;
      txReport.contactFault <= next_contact;
      txReport.kind <= sendRestore ? KIND_RESTORE : KIND_STATUS;
    end
  end

  // ==========================================
  // receiver decode
  wire logic sysMatch = rxReport.system == mySystem;
  wire logic legal = rxReport.code != ILLEGAL_CODE;
  wire logic take = rxValid && sysMatch && legal;
  wire logic [2:0] zIdx = zoneIndex(rxReport.code);
  wire logic [7:0] zBit = 8'h01 << zIdx;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxZone <= 3'h0;
      rxChannel <= 5'h00;
    end else if (take) begin
      rxZone <= zIdx;
      rxChannel <= chanIndex(rxReport.code);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      illegalSeen <= 1'b0;
      foreignSeen <= 1'b0;
    end else begin
      if (rxValid && sysMatch && !legal) begin
        illegalSeen <= 1'b1;
      end else if (wrStrobe && paddr == REG_STAT && pwdata[STAT_ILLEGAL_BIT]) begin
        illegalSeen <= 1'b0;
      end
      if (rxValid && !sysMatch) begin
        foreignSeen <= 1'b1;
      end else if (wrStrobe && paddr == REG_STAT && pwdata[STAT_FOREIGN_BIT]) begin
        foreignSeen <= 1'b0;
      end
    end
  end

  // zone outputs: self-restoring zones return to normal on the next cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zoneOut <= 8'h00;
    end else begin
      zoneOut <= zoneOut & ~selfRestore;
      if (take && rxReport.kind == KIND_ALARM) begin
        zoneOut <= (zoneOut & ~selfRestore) | zBit;
      end else if (take && rxReport.kind == KIND_RESTORE) begin
        zoneOut <= zoneOut & ~selfRestore & ~zBit;
      end
    end
  end

  // alarm memory, set wins over write-one-to-clear
  wire logic [7:0] memSet = (take && rxReport.kind == KIND_ALARM && (armed || (unarmedAlert & zBit) != 8'h00))
    ? zBit : 8'h00;
  wire logic [7:0] memClr = (wrStrobe && paddr == REG_MEM) ? pwdata[7:0] : 8'h00;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarmMemory <= 8'h00;
    end else begin
      alarmMemory <= (alarmMemory & ~memClr) | memSet;
    end
  end

  // supervised zones record each status report seen
  wire logic [7:0] seenSet = (take && rxReport.kind == KIND_STATUS)
    ? (zBit & ~SEMI_SUPERVISED_MASK) : 8'h00;
  wire logic [7:0] seenClr = (wrStrobe && paddr == REG_STAT) ? pwdata[STAT_SEEN_LSB +: 8] : 8'h00;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      statusSeen <= 8'h00;
    end else begin
      statusSeen <= (statusSeen & ~seenClr) | seenSet;
    end
  end
endmodule

// *** dv/tzc_props.sv ***
module tzc_props import tzc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // reports
  input wire logic contactPin,
  input wire logic lowBatteryIn,
  input wire tzc_report_t txReport,
  input wire logic txValid,
  input wire tzc_report_t rxReport,
  input wire logic rxValid,
  input wire logic [7:0] zoneOut,
  input wire logic [2:0] rxZone,
  input wire logic [4:0] rxChannel
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [2:0] rxZoneField = rxReport.code[7:5];
  wire logic [4:0] rxChanField = rxReport.code[4:0];
  // ==========================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  rx_zone_a: assert property ($changed(rxZone) |-> $past(rxValid) && rxZone == $past(rxZoneField))
    else $error("zone decode wrong");
  rx_chan_a: assert property ($changed(rxChannel) |-> $past(rxValid) && rxChannel == $past(rxChanField))
    else $error("channel decode wrong");
  zone_rise_a: assert property ((zoneOut & ~$past(zoneOut)) != 8'h00 |-> $past(rxReport.kind) == KIND_ALARM)
    else $error("zone set without alarm");
  self_restore_a: assert property (zoneOut[7:6] != 2'h0 && !rxValid |=> zoneOut[7:6] == 2'h0)
    else $error("self restore zone held");
  tx_restore_a: assert property (txValid && txReport.kind == KIND_RESTORE |-> !$past(contactPin, 3))
    else $error("restore without clearing");
  tx_battery_a: assert property (txValid |-> txReport.lowBattery == $past(lowBatteryIn))
    else $error("battery flag lost");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
  pready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule

// *** dv/tzc_tx_model.sv ***
module tzc_tx_model import tzc_pkg::*; (
  // clock and request
  input wire logic clk,
  input wire logic go,
  input wire tzc_kind_t kind,
  input wire logic [7:0] sysCode,
  input wire logic [7:0] code,
  // report
  output tzc_report_t rxReport,
  output logic rxValid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxReport = '0;
  initial rxValid = 1'h0;
  // ==========================================
  // one strobe per request
  always @(posedge clk) begin
    rxValid <= go;
    if (go) begin
      rxReport <= '{kind, sysCode, code, 1'h0, 1'h1};
    end else begin
      rxReport <= ~rxReport;
    end
  end
endmodule

// *** dv/tb.sv ***
module tb import tzc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, contactPin, lowBatteryIn, txValid, rxValid, go;
  logic [7:0] paddr, pc, ps, zoneOut;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] rxZone;
  logic [4:0] rxChannel;
  tzc_report_t txReport, rxReport, tr;
  logic err;
  tzc_kind_t pk;
  int numErrors, nCompared, cyc;
  bit f;
  tzc_zone_channel #(.STATUS_CYCLES(50)) uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .contactPin(contactPin),
    .lowBatteryIn(lowBatteryIn), .txReport(txReport), .txValid(txValid), .rxReport(rxReport), .rxValid(rxValid),
    .zoneOut(zoneOut), .rxZone(rxZone), .rxChannel(rxChannel));
  tzc_tx_model model (.clk(clk), .go(go), .kind(pk), .sysCode(ps), .code(pc), .rxReport(rxReport), .rxValid(rxValid));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      numErrors++;
      finish_test();
    end
  end
  // ==========================================
  // tasks
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      numErrors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rx(input tzc_kind_t k, input logic [7:0] s, input logic [7:0] c);
    @(posedge clk);
    go <= 1'h1;
    pk <= k;
    ps <= s;
    pc <= c;
    @(posedge clk);
    go <= 1'h0;
    @(posedge clk);
    #1;
  endtask
  task wt(input tzc_kind_t k, input int n);
    f = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (txValid === 1'h1 && txReport.kind === k) begin
        f = 1;
        tr = txReport;
      end
    end
  endtask
  task toggle;
    @(posedge clk);
    contactPin <= 1'h1;
    repeat (8) @(posedge clk);
    contactPin <= 1'h0;
  endtask
  task finish_test;
    if (numErrors == 0 && nCompared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================
  // sequence
  initial begin
    {psel, penable, pwrite, go, contactPin, paddr, pwdata, ps, pc} = '0;
    {cyc, numErrors, nCompared} = '0;
    pk = KIND_ALARM;
    lowBatteryIn = 1'h1;
    rst = 1'h1;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    apb(1'h0, REG_CTRL, 32'h0);
    chk("ctrl", CTRL_RESET, rd);
    chk("pslverr", 0, err);
    apb(1'h1, REG_CTRL, 32'h03c0_5a00);
    apb(1'h0, REG_ZONE, 32'h0);
    chk("zone", 32'hc0e0_0700, rd);
    apb(1'h0, REG_MEM, 32'h0);
    chk("mem", 32'h3f00, rd & 32'hff00);
    for (int z = 0; z < 8; z++) begin
      rx(KIND_ALARM, 8'h5a, {3'(z), 5'((z * 5 + 31) % 32)});
      chk("rxZone", z, rxZone);
      chk("rxChannel", (z * 5 + 31) % 32, rxChannel);
      chk("zoneOut", z < 6 ? (2 << z) - 1 : 8'h3f | (1 << z), zoneOut);
    end
    @(posedge clk);
    #1;
    chk("zoneOut", 8'h3f, zoneOut);
    rx(KIND_RESTORE, 8'h5a, 8'h60);
    chk("zoneOut", 8'h37, zoneOut);
    rx(KIND_ALARM, 8'ha5, 8'h68);
    chk("rxChannel", 0, rxChannel);
    chk("zoneOut", 8'h37, zoneOut);
    rx(KIND_STATUS, 8'h5a, 8'he1);
    rx(KIND_STATUS, 8'h5a, 8'h61);
    rx(KIND_ALARM, 8'h5a, 8'hff);
    apb(1'h0, REG_STAT, 32'h0);
    chk("stat", 32'h081b, rd & 32'hff1f);
    apb(1'h0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("pslverr", 1, err);
    apb(1'h1, REG_STAT, 32'hff18);
    apb(1'h0, REG_STAT, 32'h0);
    chk("stat", 32'h3, rd & 32'hff1f);
    apb(1'h0, REG_MEM, 32'h0);
    chk("mem", 32'h3fff, rd & 32'hffff);
    apb(1'h1, REG_MEM, 32'hff);
    rx(KIND_TEST, 8'h5a, 8'h48);
    chk("rxChannel", 8, rxChannel);
    chk("zoneOut", 8'h37, zoneOut);
    toggle();
    wt(KIND_RESTORE, 10);
    chk("restore", 1, f);
    chk("txReport", 32'h005a_0000, {tr.system, tr.code, 7'h0, tr.contactFault});
    lowBatteryIn <= 1'h0;
    wt(KIND_STATUS, 60);
    chk("status", 1, f);
    chk("lowBattery", 0, tr.lowBattery);
    apb(1'h1, REG_CTRL, 32'h01ff_5ae0);
    apb(1'h0, REG_ZONE, 32'h0);
    chk("zone", 32'hfce0_0703, rd);
    rx(KIND_ALARM, 8'h5a, 8'h20);
    rx(KIND_ALARM, 8'h5a, 8'hc2);
    apb(1'h0, REG_MEM, 32'h0);
    chk("mem", 32'h3f40, rd & 32'hffff);
    toggle();
    wt(KIND_RESTORE, 10);
    chk("restore", 0, f);
    wt(KIND_STATUS, 110);
    chk("status", 0, f);
    finish_test();
  end
endmodule
bind tzc_zone_channel tzc_props u_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .contactPin(contactPin), .lowBatteryIn(lowBatteryIn), .txReport(txReport), .txValid(txValid),
  .rxReport(rxReport), .rxValid(rxValid), .zoneOut(zoneOut), .rxZone(rxZone), .rxChannel(rxChannel));
